/* File: hw/wr_retire_defs.svh */
`ifndef WR_RETIRE_DEFS_SVH
`define WR_RETIRE_DEFS_SVH
// column packet slots from a store to its first retire opportunity
`define RETIRE_DLY_SLOTS 2
// least packet slots between two row activations (row_to_row_interval)
`define ROW_TO_ROW_SLOTS 4
// width of the row-to-row interval slot counter
`define RR_CNT_W 4
// buffer states, gray along empty -> aging -> ripe
`define BUF_EMPTY 2'h0
`define BUF_AGING 2'h1
`define BUF_RIPE 2'h3
// column command encodings
`define CMD_IDLE 3'h0
`define CMD_STORE 3'h1
`define CMD_STORE_AC 3'h2
`define CMD_FETCH 3'h3
`define CMD_FETCH_AC 3'h4
`endif

/* File: hw/wr_retire_pkg.sv */
`default_nettype none
`include "wr_retire_defs.svh"
package wr_retire_pkg;
   typedef enum logic [2:0] {
      col_idle_cmd            = `CMD_IDLE,
      col_store_cmd           = `CMD_STORE,
      col_store_autoclose_cmd = `CMD_STORE_AC,
      col_fetch_cmd           = `CMD_FETCH,
      col_fetch_autoclose_cmd = `CMD_FETCH_AC
   } col_cmd_t;

   typedef enum logic [1:0] {
      buf_empty = `BUF_EMPTY,
      buf_aging = `BUF_AGING,
      buf_ripe  = `BUF_RIPE
   } buf_state_t;

   // one column_cmd_packet slot
   typedef struct packed {
      logic       framed;
      col_cmd_t   cmd;
      logic [4:0] dev;
      logic [4:0] bank;
      logic [5:0] column;
   } column_cmd_packet_t;

   // held write: bank and column only, never the row
   typedef struct packed {
      logic [4:0]   bank;
      logic [5:0]   column;
      logic         autoclose;
      logic [127:0] data;
   } wbuf_entry_t;
endpackage
`default_nettype wire

/* File: hw/slot_delay.sv */
`timescale 1ns/100ps
`default_nettype none
// delays a single-bit event by DEPTH packet slots
module slot_delay #(
   parameter int DEPTH = 2
) (
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic adv_i,
   input  wire logic in_i,
   output logic      out_o
);
   logic [DEPTH-1:0] pipe_q;
   // one spare bit lets the same shift serve a depth of one
   wire  [DEPTH:0]   shift_w = {pipe_q, in_i};

   assign out_o = pipe_q[DEPTH-1];

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         pipe_q <= '0;
      end else if (adv_i) begin
         pipe_q <= shift_w[DEPTH-1:0];
      end
   end
endmodule
`default_nettype wire

/* File: hw/wr_retire.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wr_retire_defs.svh"
// Behaviour
// - retire buffer at slot one delay after store, unless unframed or own fetch
// - own fetches hold retire pending; other fetch, store or idle releases it
// - byte mask from mask packet aligned with retiring slot is applied
// - buffer keeps bank and column only; retire uses the bank's last activated row, open or not
// - a store to another device retires our ripe buffer
// - activations may follow each other once per row-to-row interval
// - autoclose store closes its bank when it retires
// - each store carries a full dualoct over both data lanes
// - extended packet precharge closes banks for reads
// - extended packet precharge refused while bank holds a masked write
module wr_retire
   import wr_retire_pkg::*;
#(
   parameter int BANKS    = 32,
   parameter int ROW_W    = 9,
   parameter int DLY      = `RETIRE_DLY_SLOTS,
   parameter int RR_SLOTS = `ROW_TO_ROW_SLOTS
) (
   input  wire logic               clk_sys_i,
   input  wire logic               reset_i,
   input  wire logic               ce_i,
   input  wire logic               slot_i,
   input  wire logic [4:0]         dev_id_i,
   input  wire column_cmd_packet_t col_pkt_i,
   input  wire logic [63:0]        data_lane_a_i,
   input  wire logic [63:0]        data_lane_b_i,
   input  wire logic               mask_valid_i,
   input  wire logic [15:0]        byte_mask_i,
   input  wire logic               ext_pre_i,
   input  wire logic [4:0]         ext_pre_bank_i,
   input  wire logic               row_act_i,
   input  wire logic               row_pre_i,
   input  wire logic [4:0]         row_bank_i,
   input  wire logic [ROW_W-1:0]   row_addr_i,
   output logic                    retire_o,
   output logic [4:0]              retire_bank_o,
   output logic [5:0]              retire_col_o,
   output logic [ROW_W-1:0]        retire_row_o,
   output logic [127:0]            retire_data_o,
   output logic [15:0]             retire_mask_o,
   output logic                    bank_close_o,
   output logic [4:0]              bank_close_idx_o,
   output logic                    store_reject_o,
   output logic                    ext_pre_reject_o,
   output logic                    act_early_o,
   output logic                    pending_o
);
   buf_state_t             st_q, st_d;
   wbuf_entry_t            ent_q;
   logic [BANKS-1:0]       open_q;
   logic [ROW_W-1:0]       row_q [BANKS];
   logic [`RR_CNT_W-1:0]   rr_q;
   logic                   aged_w;

   wire pkt_w       = ce_i & slot_i & col_pkt_i.framed;
   wire mine_w      = col_pkt_i.dev == dev_id_i;
   wire is_fetch_w  = col_pkt_i.cmd == col_fetch_cmd || col_pkt_i.cmd == col_fetch_autoclose_cmd;
   wire is_store_w  = col_pkt_i.cmd == col_store_cmd || col_pkt_i.cmd == col_store_autoclose_cmd;
   wire fetch_me_w  = pkt_w & is_fetch_w & mine_w;
   wire store_me_w  = pkt_w & is_store_w & mine_w;
   wire ripe_w      = (st_q == buf_ripe) | ((st_q == buf_aging) & aged_w);
   // own fetch keeps holding the retire; anything else framed releases it
   wire retire_w    = ripe_w & pkt_w & ~fetch_me_w;
   wire accept_w    = store_me_w & ((st_q == buf_empty) | retire_w);
   wire reject_w    = store_me_w & ~accept_w;
   // any held write may carry a mask, so its bank refuses the extended precharge
   wire ext_bad_w   = ext_pre_i & (st_q != buf_empty) & (ent_q.bank == ext_pre_bank_i);
   wire ext_ok_w    = ce_i & ext_pre_i & ~ext_bad_w;
   wire close_ac_w  = retire_w & ent_q.autoclose;
   wire act_w       = ce_i & row_act_i;
   wire early_w     = act_w & (rr_q < RR_SLOTS[`RR_CNT_W-1:0]);
   // no mask packet in the retiring slot writes every byte
   wire [15:0] mask_w = mask_valid_i ? byte_mask_i : 16'hFFFF;
   wire [ROW_W-1:0] cur_row_w = row_q[ent_q.bank];

   // only slot strobes age a store; gaps between slots do not count
   slot_delay #(
      .DEPTH (DLY)
   ) u_age (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .adv_i     (ce_i & slot_i),
      .in_i      (accept_w),
      .out_o     (aged_w)
   );

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         buf_empty: if (accept_w) st_d = buf_aging;
         buf_aging: if (accept_w) st_d = buf_aging;
                    else if (retire_w) st_d = buf_empty;
                    else if (ce_i & slot_i & aged_w) st_d = buf_ripe;
         buf_ripe:  if (accept_w) st_d = buf_aging;
                    else if (retire_w) st_d = buf_empty;
         default:   st_d = buf_empty;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= buf_empty;
         ent_q <= '0;
      end else if (ce_i) begin
         st_q <= st_d;
         if (accept_w) begin
            // both lanes form one dualoct
            ent_q <= {col_pkt_i.bank, col_pkt_i.column, col_pkt_i.cmd == col_store_autoclose_cmd,
                      data_lane_a_i, data_lane_b_i};
         end
      end
   end

   // open row per bank; no reset on rows, and retire reads them without checking the open flag
   always_ff @(posedge clk_sys_i) begin
      if (ce_i & row_act_i) begin
         row_q[row_bank_i] <= row_addr_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         open_q <= '0;
         // saturated at reset so the first activation is never flagged
         rr_q <= '1;
      end else if (ce_i) begin
         if (row_pre_i) open_q[row_bank_i] <= 1'b0;
         if (ext_ok_w) open_q[ext_pre_bank_i] <= 1'b0;
         if (close_ac_w) open_q[ent_q.bank] <= 1'b0;
         if (row_act_i) open_q[row_bank_i] <= 1'b1;
         // the slot after an activation is already one slot since it
         if (act_w) rr_q <= `RR_CNT_W'(1);
         else if (slot_i && rr_q != '1) rr_q <= rr_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         retire_o <= 1'b0;
         retire_bank_o <= '0;
         retire_col_o <= '0;
         retire_row_o <= '0;
         retire_data_o <= '0;
         retire_mask_o <= '0;
         bank_close_o <= 1'b0;
         bank_close_idx_o <= '0;
         store_reject_o <= 1'b0;
         ext_pre_reject_o <= 1'b0;
         act_early_o <= 1'b0;
         pending_o <= 1'b0;
      end else if (ce_i) begin
         retire_o <= retire_w;
         if (retire_w) begin
            retire_bank_o <= ent_q.bank;
            retire_col_o <= ent_q.column;
            retire_row_o <= cur_row_w;
            retire_data_o <= ent_q.data;
            retire_mask_o <= mask_w;
         end
         bank_close_o <= close_ac_w | ext_ok_w;
         bank_close_idx_o <= close_ac_w ? ent_q.bank : ext_pre_bank_i;
         store_reject_o <= reject_w;
         ext_pre_reject_o <= ce_i & ext_bad_w;
         act_early_o <= early_w;
         pending_o <= st_d != buf_empty;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   retire_on_slot_a: assert property (retire_w |=> retire_o && retire_bank_o == $past(ent_q.bank))
      else $error("retire missed at ripe slot");
   fetch_holds_a: assert property (fetch_me_w && !store_me_w |=> !retire_o)
      else $error("own fetch did not hold retire");
   mask_aligned_a: assert property (retire_w && mask_valid_i |=> retire_mask_o == $past(byte_mask_i))
      else $error("byte mask not applied at retire");
   open_row_used_a: assert property (retire_w |=> retire_row_o == $past(cur_row_w))
      else $error("retire did not use open row");
   other_store_a: assert property (ripe_w && pkt_w && is_store_w && !mine_w |=> retire_o)
      else $error("foreign store did not retire buffer");
   autoclose_a: assert property (close_ac_w |=> bank_close_o && !open_q[$past(ent_q.bank)])
      else $error("autoclose store left bank open");
   ext_refused_a: assert property (ce_i && ext_bad_w |=> ext_pre_reject_o && !bank_close_o ##0 pending_o)
      else $error("precharge over held write not refused");
   single_entry_a: assert property (store_me_w && st_q != buf_empty && !retire_w |=> store_reject_o)
      else $error("second store accepted without retire");
   rr_spacing_a: assert property (act_w ##1 act_w |=> act_early_o)
      else $error("close activations not flagged");
   unframed_hold_a: assert property (ce_i && slot_i && !col_pkt_i.framed |=> !retire_o)
      else $error("retire in unframed slot");
   hold_entry_a: assert property (fetch_me_w && ripe_w |=> pending_o)
      else $error("held write lost on own fetch");
   dualoct_kept_a: assert property (retire_w |=> retire_data_o == $past(ent_q.data))
      else $error("retired dualoct differs from held one");
   ext_close_a: assert property (ext_ok_w && !close_ac_w |=>
      bank_close_o && bank_close_idx_o == $past(ext_pre_bank_i))
      else $error("extended precharge did not close bank");
   idle_no_retire_a: assert property (ce_i && st_q == buf_empty |=> !retire_o)
      else $error("retire from empty buffer");
   store_taken_a: assert property (accept_w |=> pending_o)
      else $error("accepted store not held");

   // main scenarios: held retire, back-to-back store, reads, gaps, close activations
   delayed_retire_c: cover property (fetch_me_w && ripe_w ##[1:8] retire_w);
   retire_and_store_c: cover property (retire_w && accept_w);
   ext_pre_read_c: cover property (ext_ok_w);
   unframed_slot_c: cover property (ripe_w && ce_i && slot_i && !col_pkt_i.framed);
   early_act_c: cover property (early_w);
endmodule
`default_nettype wire

/* File: dv/ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// controller stand-in: each tx clock carries one column packet, a gap clock carries none; the testbench drops slot_i for some clocks
module ctl_model
   import wr_retire_pkg::*;
(
   input  wire logic          clk_sys_i,
   output column_cmd_packet_t pkt_o,
   output logic [127:0]       wdat_o,
   output logic               mv_o,
   output logic [15:0]        msk_o,
   output logic [16:0]        side_o
);
   // {act, pre, ext, bank, row}, goes out with the next slot only
   logic [16:0] req = '0;
   initial begin
      pkt_o = '0;
      wdat_o = '0;
      mv_o = 1'b0;
      msk_o = 16'hFFFF;
      side_o = '0;
   end
   task automatic tx(input col_cmd_t c, input logic [4:0] d, input logic [4:0] b, input logic [15:0] m);
      pkt_o <= '{1'b1, c, d, b, 6'h09};
      // lanes released outside store slots: inverse, never stale data
      wdat_o <= (c inside {col_store_cmd, col_store_autoclose_cmd}) ? {b, 123'h0ABC} : ~wdat_o;
      mv_o <= m !== 16'hFFFF;
      msk_o <= m;
      side_o <= req;
      req = '0;
      @(posedge clk_sys_i);
   endtask
   // slot with no column packet framed
   task automatic gap();
      pkt_o <= '0;
      wdat_o <= ~wdat_o;
      mv_o <= 1'b0;
      msk_o <= 16'hFFFF;
      side_o <= req;
      req = '0;
      @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

/* File: dv/wr_retire_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module wr_retire_tb_top
   import wr_retire_pkg::*;
;
   localparam logic [4:0] ME = 5'h03;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic slot = 1'b1;
   column_cmd_packet_t pkt;
   logic [127:0] wdat, retire_data_o;
   logic [16:0] side;
   logic [15:0] msk, retire_mask_o;
   logic mv, retire_o, bank_close_o, store_reject_o, ext_pre_reject_o, act_early_o, pending_o;
   logic [4:0] retire_bank_o, bank_close_idx_o;
   logic [5:0] retire_col_o;
   logic [8:0] retire_row_o;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   ctl_model ctl_model_i (.clk_sys_i, .pkt_o(pkt), .wdat_o(wdat), .mv_o(mv), .msk_o(msk), .side_o(side));
   wr_retire wr_retire_i (.clk_sys_i, .reset_i, .ce_i(1'b1), .slot_i(slot), .dev_id_i(ME), .col_pkt_i(pkt),
      .data_lane_a_i(wdat[127:64]), .data_lane_b_i(wdat[63:0]), .mask_valid_i(mv), .byte_mask_i(msk),
      .ext_pre_i(side[14]), .ext_pre_bank_i(side[13:9]), .row_act_i(side[16]), .row_pre_i(side[15]),
      .row_bank_i(side[13:9]), .row_addr_i(side[8:0]), .retire_o, .retire_bank_o, .retire_col_o,
      .retire_row_o, .retire_data_o, .retire_mask_o, .bank_close_o, .bank_close_idx_o, .store_reject_o,
      .ext_pre_reject_o, .act_early_o, .pending_o);
   initial forever #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         failures++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // outputs read at an edge still show the previous edge's result
   task automatic tx(input col_cmd_t c, input logic [4:0] d, input logic [4:0] b, input logic [15:0] m = 16'hFFFF);
      ctl_model_i.tx(c, d, b, m);
   endtask
   task automatic idle(input int n);
      repeat (n) tx(col_idle_cmd, ME, 5'h00);
   endtask
   task automatic ret_chk(input logic [4:0] b);
      chk("retire", 1'b1, retire_o);
      chk("retire_bank", b, retire_bank_o);
      chk("retire_col", 6'h09, retire_col_o);
      chk("retire_data", {b, 123'h0ABC}, retire_data_o);
   endtask
   task automatic t_normal();
      tx(col_store_cmd, ME, 5'h05);
      idle(1);
      chk("pending", 1'b1, pending_o);
      idle(1);
      chk("early retire", 1'b0, retire_o);
      tx(col_fetch_cmd, ME, 5'h0C);
      ret_chk(5'h05);
      chk("mask", 16'hFFFF, retire_mask_o);
      $display("normal done");
   endtask
   task automatic t_held();
      ctl_model_i.req = {3'b100, 5'h05, 9'h011};
      tx(col_store_cmd, ME, 5'h05);
      idle(1);
      ctl_model_i.req = {3'b010, 5'h05, 9'h000};
      tx(col_fetch_cmd, ME, 5'h02);
      ctl_model_i.req = {3'b100, 5'h05, 9'h022};
      tx(col_fetch_autoclose_cmd, ME, 5'h03);
      chk("held", 1'b0, retire_o);
      tx(col_fetch_cmd, 5'h07, 5'h02, 16'h00F0);
      idle(1);
      ret_chk(5'h05);
      chk("row", 9'h022, retire_row_o);
      chk("mask", 16'h00F0, retire_mask_o);
      $display("held done");
   endtask
   task automatic t_other();
      tx(col_store_cmd, ME, 5'h06);
      idle(1);
      tx(col_fetch_cmd, ME, 5'h00);
      ctl_model_i.gap();
      tx(col_store_cmd, 5'h01, 5'h00);
      chk("unframed hold", 1'b0, retire_o);
      idle(1);
      ret_chk(5'h06);
      $display("other done");
   endtask
   task automatic t_reject();
      tx(col_store_cmd, ME, 5'h01);
      tx(col_store_cmd, ME, 5'h02);
      tx(col_store_cmd, ME, 5'h03);
      chk("reject", 1'b1, store_reject_o);
      idle(1);
      ret_chk(5'h01);
      chk("no reject", 1'b0, store_reject_o);
      idle(2);
      ret_chk(5'h03);
      $display("reject done");
   endtask
   task automatic t_ext();
      tx(col_store_cmd, ME, 5'h07);
      ctl_model_i.req = {3'b001, 5'h07, 9'h000};
      idle(2);
      chk("pre refused", 1'b1, ext_pre_reject_o);
      ctl_model_i.req = {3'b001, 5'h07, 9'h000};
      idle(2);
      chk("pre close", 1'b1, bank_close_o);
      chk("pre bank", 5'h07, bank_close_idx_o);
      $display("ext done");
   endtask
   task automatic t_close();
      tx(col_store_autoclose_cmd, ME, 5'h09);
      slot <= 1'b0;
      idle(1);
      slot <= 1'b1;
      idle(2);
      chk("no slot retire", 1'b0, retire_o);
      idle(1);
      ret_chk(5'h09);
      chk("close", 1'b1, bank_close_o);
      chk("close bank", 5'h09, bank_close_idx_o);
      $display("close done");
   endtask
   task automatic t_act();
      ctl_model_i.req = {3'b100, 5'h02, 9'h001};
      idle(1);
      ctl_model_i.req = {3'b100, 5'h04, 9'h001};
      idle(2);
      chk("early act", 1'b1, act_early_o);
      idle(1);
      ctl_model_i.req = {3'b100, 5'h06, 9'h001};
      idle(2);
      chk("act three slots", 1'b1, act_early_o);
      idle(2);
      ctl_model_i.req = {3'b100, 5'h02, 9'h001};
      idle(2);
      chk("spaced act", 1'b0, act_early_o);
      $display("act done");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_normal();
      t_held();
      t_other();
      t_reject();
      t_ext();
      t_close();
      t_act();
      summarize();
   end
endmodule
`default_nettype wire
